// File: logic/sfrr_pkg.sv
// shared constants and types for the serial flash reset and recovery pair
package sfrr_pkg;

    // ==========================================================
    // clock and timing
    // ==========================================================
    localparam int CLK_MHZ                  = 200;
    localparam int RESET_LOW_PULSE_MIN_US   = 10;
    localparam int RESET_HIGH_TO_SELECT_US  = 10;
    localparam int RECOV_DECODE_US          = 40;
    localparam int RECOV_READ_US            = 35;
    localparam int RECOV_PROGRAM_US         = 310;
    localparam int RECOV_SECTOR_MS          = 12;
    localparam int RECOV_BLOCK_MS           = 25;
    localparam int RECOV_CHIP_MS            = 100;
    localparam int RECOV_STATUS_MS          = 40;
    localparam int RECOV_STANDBY_US         = 35;

    // cycle counts derived from the clock rate
    localparam int RESET_LOW_CYC   = RESET_LOW_PULSE_MIN_US * CLK_MHZ;
    localparam int SELECT_WAIT_CYC = RESET_HIGH_TO_SELECT_US * CLK_MHZ;
    localparam int RECOV_DECODE_CYC  = RECOV_DECODE_US * CLK_MHZ;
    localparam int RECOV_READ_CYC    = RECOV_READ_US * CLK_MHZ;
    localparam int RECOV_PROGRAM_CYC = RECOV_PROGRAM_US * CLK_MHZ;
    localparam int RECOV_SECTOR_CYC  = RECOV_SECTOR_MS * 1000 * CLK_MHZ;
    localparam int RECOV_BLOCK_CYC   = RECOV_BLOCK_MS * 1000 * CLK_MHZ;
    localparam int RECOV_CHIP_CYC    = RECOV_CHIP_MS * 1000 * CLK_MHZ;
    localparam int RECOV_STATUS_CYC  = RECOV_STATUS_MS * 1000 * CLK_MHZ;
    localparam int RECOV_STANDBY_CYC = RECOV_STANDBY_US * CLK_MHZ;

    localparam int CNT_W = 25;

    // ==========================================================
    // opcodes
    // ==========================================================
    localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
    localparam logic [7:0] OP_RESET        = 8'h99;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_PROGRAM      = 8'h02;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
    localparam logic [7:0] OP_BLOCK_ERASE_M = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE_L = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE   = 8'h60;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_BLOCK_LOCK   = 8'he1;

    // ==========================================================
    // misc widths and reset values
    // ==========================================================
    localparam int           LOCK_N       = 16;
    localparam logic [15:0]  LOCK_DEFAULT = 16'hffff;
    localparam logic         ADDR4_DEFAULT = 1'b0;

    // activity interrupted by a reset, picks the recovery time
    typedef enum logic [2:0] {
        SFRR_ACT_IDLE, SFRR_ACT_DECODE, SFRR_ACT_READ, SFRR_ACT_PROGRAM,
        SFRR_ACT_SECTOR, SFRR_ACT_BLOCK, SFRR_ACT_CHIP, SFRR_ACT_STATUS
    } sfrr_act_e;

endpackage : sfrr_pkg

// File: logic/sfrr_if.sv
// pin-level link between host controller and flash reset logic
`timescale 1ns/100ps
`default_nettype none
interface sfrr_if;
    logic       reset_n;     // hardware reset, active low
    logic       cs_n;        // chip select, active low
    logic       cmd_valid;   // byte strobe on serial bus
    logic [7:0] cmd_byte;    // command byte
    logic       cmd_last;    // select rises after this byte
    logic       so_out;      // serial data output
    logic       so_oe;       // output enable of serial data
    logic       ready;       // device accepts commands

    modport device (input reset_n, cs_n, cmd_valid, cmd_byte, cmd_last,
                    output so_out, so_oe, ready);
    modport host   (output reset_n, cs_n, cmd_valid, cmd_byte, cmd_last,
                    input so_out, so_oe, ready);
endinterface : sfrr_if
`default_nettype wire

// File: logic/sfrr_device.sv
// flash device end: reset, abort, recovery and software reset sequence
//
// Overview of operation
// - reset low ten microseconds gives full reset
// - after reset: standby, three-byte addressing
// - reset clears all volatile bits to defaults
// - reset aborts running program or erase
// - serial output floats while reset held
// - host waits ten microseconds before select
// - decode interrupted: ready within forty microseconds
// - read interrupted: ready within thirty-five microseconds
// - program interrupted: ready within 310 microseconds
// - sector erase interrupted: ready within 12 ms
// - block erase interrupted: ready within 25 ms
// - chip erase interrupted: ready within 100 ms
// - status write interrupted: ready within 40 ms
// - software reset is 66h then 99h
//
`timescale 1ns/100ps
`default_nettype none
module sfrr_device
    import sfrr_pkg::*;
#(
    parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
    parameter int OP_BUSY_CYCLES   = 1000,
    parameter int RECOV_DECODE     = RECOV_DECODE_CYC,
    parameter int RECOV_READ       = RECOV_READ_CYC,
    parameter int RECOV_PROGRAM    = RECOV_PROGRAM_CYC,
    parameter int RECOV_SECTOR     = RECOV_SECTOR_CYC,
    parameter int RECOV_BLOCK      = RECOV_BLOCK_CYC,
    parameter int RECOV_CHIP       = RECOV_CHIP_CYC,
    parameter int RECOV_STATUS     = RECOV_STATUS_CYC,
    parameter int RECOV_STANDBY    = RECOV_STANDBY_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst_b,
    sfrr_if.device           bus,
    output logic             write_enable_latch,
    output logic             write_in_progress,
    output logic             addr_4byte,
    output logic [LOCK_N-1:0] lock_bits,
    output logic             op_aborted,
    output logic             data_corrupt,
    output logic             sw_reset_done
);

    // ==========================================================
    // recovery time lookup
    // ==========================================================
    function automatic logic [CNT_W-1:0] recov_for(input sfrr_act_e a);
        logic [CNT_W-1:0] r;
        r = CNT_W'(RECOV_STANDBY);
        case (a)
            SFRR_ACT_DECODE:  r = CNT_W'(RECOV_DECODE);
            SFRR_ACT_READ:    r = CNT_W'(RECOV_READ);
            SFRR_ACT_PROGRAM: r = CNT_W'(RECOV_PROGRAM);
            SFRR_ACT_SECTOR:  r = CNT_W'(RECOV_SECTOR);
            SFRR_ACT_BLOCK:   r = CNT_W'(RECOV_BLOCK);
            SFRR_ACT_CHIP:    r = CNT_W'(RECOV_CHIP);
            SFRR_ACT_STATUS:  r = CNT_W'(RECOV_STATUS);
            default:          r = CNT_W'(RECOV_STANDBY);
        endcase
        return r;
    endfunction : recov_for

    typedef enum logic [1:0] {
        SFRR_ST_READY, SFRR_ST_IN_RESET, SFRR_ST_RECOVER
    } sfrr_state_e;

    sfrr_state_e      state;
    sfrr_act_e        activity;
    sfrr_act_e        hit_act;
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] busy_cnt;
    logic             rst_full;
    logic             reset_en_armed;
    logic             in_cmd;
    logic             accept;
    logic             sw_reset_hit;
    logic             do_reset;

    // bytes are taken only when ready and selected
    assign accept = (state == SFRR_ST_READY) && !bus.cs_n
                    && bus.cmd_valid;
    assign sw_reset_hit = accept && (bus.cmd_byte == OP_RESET)
                          && reset_en_armed && !in_cmd;
    assign rst_full = (state == SFRR_ST_IN_RESET)
                      && (cnt >= CNT_W'(RESET_LOW_CYCLES));
    // a full reset takes effect on release of a long enough pulse
    assign do_reset = (rst_full && bus.reset_n) || sw_reset_hit;

    // ==========================================================
    // reset pin, recovery timer, state
    // ==========================================================
    // count low time, then recovery time after release
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            state <= SFRR_ST_RECOVER;
            cnt   <= CNT_W'(RECOV_STANDBY);
            hit_act <= SFRR_ACT_IDLE;
        end
        else if (!bus.reset_n && state != SFRR_ST_IN_RESET)
        begin
            state   <= SFRR_ST_IN_RESET;
            cnt     <= CNT_W'(1);                  // this low cycle counts
            hit_act <= in_cmd ? SFRR_ACT_DECODE : activity;
        end
        else if (sw_reset_hit)
        begin
            state <= SFRR_ST_RECOVER;
            cnt   <= recov_for(activity);
        end
        else
        begin
            case (state)
                SFRR_ST_IN_RESET:
                begin
                    if (bus.reset_n)
                    begin
                        // short pulses skip the recovery wait and return straight to ready
                        state <= rst_full ? SFRR_ST_RECOVER : SFRR_ST_READY;
                        cnt   <= recov_for(hit_act);
                    end
                    else if (!rst_full)
                        cnt <= cnt + CNT_W'(1);
                end
                SFRR_ST_RECOVER:
                begin
                    if (cnt <= CNT_W'(1))
                        state <= SFRR_ST_READY;
                    cnt <= (cnt == '0) ? '0 : cnt - CNT_W'(1);
                end
                SFRR_ST_READY:
                    state <= SFRR_ST_READY;
                default:
                    state <= SFRR_ST_READY;
            endcase
        end
    end

    // ==========================================================
    // command tracking
    // ==========================================================
    // opcode position within a select and reset-enable arming
    always_ff @(posedge clk)
    begin
        if (!rst_b || do_reset || state != SFRR_ST_READY)
        begin
            in_cmd         <= 1'b0;
            reset_en_armed <= 1'b0;
        end
        else if (accept)
        begin
            in_cmd <= !bus.cmd_last;
            if (!in_cmd)
                reset_en_armed <= (bus.cmd_byte == OP_RESET_ENABLE);
        end
    end

    // ==========================================================
    // operations and volatile state
    // ==========================================================
    // start, run and abort program, erase, read and status write
    always_ff @(posedge clk)
    begin
        if (!rst_b || do_reset || !bus.reset_n)
        begin
            activity           <= SFRR_ACT_IDLE;
            busy_cnt           <= '0;
            write_in_progress  <= 1'b0;
            write_enable_latch <= 1'b0;
            addr_4byte         <= ADDR4_DEFAULT;
            lock_bits          <= LOCK_DEFAULT;
        end
        else if (accept && !in_cmd)
        begin
            case (bus.cmd_byte)
                OP_WRITE_ENABLE: write_enable_latch <= 1'b1;
                OP_READ:         activity <= SFRR_ACT_READ;
                OP_BLOCK_LOCK:   lock_bits <= '0;
                default:
                begin
                    if (write_enable_latch && !write_in_progress)
                    begin
                        write_in_progress <= 1'b1;
                        busy_cnt <= CNT_W'(OP_BUSY_CYCLES);
                        write_enable_latch <= 1'b0;
                        case (bus.cmd_byte)
                            OP_PROGRAM:       activity <= SFRR_ACT_PROGRAM;
                            OP_SECTOR_ERASE:  activity <= SFRR_ACT_SECTOR;
                            OP_BLOCK_ERASE_M: activity <= SFRR_ACT_BLOCK;
                            OP_BLOCK_ERASE_L: activity <= SFRR_ACT_BLOCK;
                            OP_CHIP_ERASE:    activity <= SFRR_ACT_CHIP;
                            OP_STATUS_WRITE:  activity <= SFRR_ACT_STATUS;
                            default:
                            begin
                                write_in_progress <= 1'b0;
                                write_enable_latch <= 1'b1;
                            end
                        endcase
                    end
                end
            endcase
        end
        else if (write_in_progress)
        begin
            busy_cnt <= busy_cnt - CNT_W'(1);
            if (busy_cnt <= CNT_W'(1))
            begin
                write_in_progress <= 1'b0;
                activity <= SFRR_ACT_IDLE;
            end
        end
        else if (activity == SFRR_ACT_READ && bus.cs_n)
            activity <= SFRR_ACT_IDLE;
    end

    // abort reporting: operation lost, contents may be corrupt
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            op_aborted   <= 1'b0;
            data_corrupt <= 1'b0;
        end
        else
        begin
            op_aborted <= !bus.reset_n && write_in_progress;
            if (!bus.reset_n && write_in_progress)
                data_corrupt <= 1'b1;
        end
    end

    // ==========================================================
    // pin outputs
    // ==========================================================
    // output floats during reset and recovery, ready flag registered
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bus.so_out    <= 1'b0;
            bus.so_oe     <= 1'b0;
            bus.ready     <= 1'b0;
            sw_reset_done <= 1'b0;
        end
        else
        begin
            bus.so_out <= write_in_progress;
            bus.so_oe  <= bus.reset_n && !bus.cs_n
                          && state == SFRR_ST_READY;
            bus.ready  <= bus.reset_n && state == SFRR_ST_READY
                          && !do_reset;
            sw_reset_done <= sw_reset_hit;
        end
    end

endmodule : sfrr_device
`default_nettype wire

// File: logic/sfrr_host.sv
// host controller end: drives reset pulse, waits recovery, sends bytes
`timescale 1ns/100ps
`default_nettype none
module sfrr_host
    import sfrr_pkg::*;
#(
    parameter int RESET_LOW_CYCLES = RESET_LOW_CYC,
    parameter int SELECT_WAIT      = SELECT_WAIT_CYC,
    parameter int RECOV_WAIT       = RECOV_CHIP_CYC
)(
    input  wire logic        clk,
    input  wire logic        rst_b,
    sfrr_if.host             bus,
    input  wire logic        hw_reset_req,
    input  wire logic        byte_req,
    input  wire logic [7:0]  byte_in,
    input  wire logic        byte_last,
    output logic             busy,
    output logic             can_send
);

    typedef enum logic [1:0] {
        SFRR_H_IDLE, SFRR_H_PULSE, SFRR_H_WAIT
    } sfrr_hstate_e;

    sfrr_hstate_e     hstate;
    logic [CNT_W-1:0] hcnt;

    // ==========================================================
    // reset pulse and hold-off sequence
    // ==========================================================
    // pulse held long enough, then wait worst recovery before select
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            hstate      <= SFRR_H_IDLE;
            hcnt        <= '0;
            bus.reset_n <= 1'b1;
        end
        else
        begin
            case (hstate)
                SFRR_H_IDLE:
                    if (hw_reset_req)
                    begin
                        hstate      <= SFRR_H_PULSE;
                        hcnt        <= CNT_W'(RESET_LOW_CYCLES);
                        bus.reset_n <= 1'b0;
                    end
                SFRR_H_PULSE:
                begin
                    hcnt <= hcnt - CNT_W'(1);
                    if (hcnt <= CNT_W'(1))
                    begin
                        hstate      <= SFRR_H_WAIT;
                        bus.reset_n <= 1'b1;
                        // longest of select wait and recovery
                        hcnt <= (RECOV_WAIT > SELECT_WAIT)
                                ? CNT_W'(RECOV_WAIT)
                                : CNT_W'(SELECT_WAIT);
                    end
                end
                SFRR_H_WAIT:
                begin
                    hcnt <= hcnt - CNT_W'(1);
                    if (hcnt <= CNT_W'(1))
                        hstate <= SFRR_H_IDLE;
                end
                default:
                    hstate <= SFRR_H_IDLE;
            endcase
        end
    end

    // ==========================================================
    // byte sending
    // ==========================================================
    // bytes pass only when idle and the device says ready
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            bus.cs_n      <= 1'b1;
            bus.cmd_valid <= 1'b0;
            bus.cmd_byte  <= 8'h00;
            bus.cmd_last  <= 1'b0;
        end
        else if (hstate == SFRR_H_IDLE && bus.ready && byte_req
                 && !hw_reset_req)
        begin
            bus.cs_n      <= 1'b0;
            bus.cmd_valid <= 1'b1;
            bus.cmd_byte  <= byte_in;
            bus.cmd_last  <= byte_last;
        end
        else
        begin
            bus.cmd_valid <= 1'b0;
            bus.cmd_last  <= 1'b0;
            if (bus.cmd_last || hstate != SFRR_H_IDLE)
                bus.cs_n <= 1'b1;
        end
    end

    // status to the user side
    always_ff @(posedge clk)
    begin
        if (!rst_b)
        begin
            busy     <= 1'b0;
            can_send <= 1'b0;
        end
        else
        begin
            busy     <= hstate != SFRR_H_IDLE;
            can_send <= hstate == SFRR_H_IDLE && bus.ready;
        end
    end

endmodule : sfrr_host
`default_nettype wire

// File: test/sfrr_properties.sv
// concurrent checks on the reset link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module sfrr_properties
#(
    parameter int RST_LOW   = 20,
    parameter int SEL_WAIT  = 20,
    parameter int MIN_RECOV = 66,
    parameter int MAX_RECOV = 320
)(
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       reset_n,
    input wire logic       cs_n,
    input wire logic       cmd_valid,
    input wire logic [7:0] cmd_byte,
    input wire logic       cmd_last,
    input wire logic       so_out,
    input wire logic       so_oe,
    input wire logic       ready
);
    logic [9:0] low_cnt;   // consecutive low cycles of reset
    logic [9:0] since_rel; // cycles since reset went high

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // helper counters
    // ==========================================================
    // length of the current reset pulse, saturating
    always_ff @(posedge clk)
    begin
        if (!rst_b || reset_n)
            low_cnt <= 10'h000;
        else if (low_cnt != 10'h3ff)
            low_cnt <= low_cnt + 10'h001;
    end

    // time since release of reset, saturating
    always_ff @(posedge clk)
    begin
        if (!rst_b || !reset_n)
            since_rel <= 10'h000;
        else if (since_rel != 10'h3ff)
            since_rel <= since_rel + 10'h001;
    end

    // ==========================================================
    // properties
    // ==========================================================
    a_pulse_width: assert property (
        $rose(reset_n) |-> low_cnt >= RST_LOW)
        else $error("reset pulse shorter than minimum");
    a_ready_drop: assert property (
        $fell(reset_n) |=> !ready)
        else $error("ready kept after reset fell");
    a_no_early_ready: assert property (
        since_rel < MIN_RECOV |-> !ready)
        else $error("ready before recovery elapsed");
    a_ready_bound: assert property (
        $rose(reset_n) |-> ##[1:MAX_RECOV] ready)
        else $error("ready late after reset release");
    a_select_gap: assert property (
        since_rel < SEL_WAIT |-> cs_n)
        else $error("select too soon after reset");
    a_oe_in_reset: assert property (
        (!reset_n) [*2] |-> !so_oe)
        else $error("serial output driven in reset");
    a_strobe_select: assert property (
        cmd_valid |-> !cs_n)
        else $error("byte strobe without select");
    a_last_deselect: assert property (
        cmd_valid && cmd_last |=> cs_n)
        else $error("select held after last byte");
endmodule : sfrr_properties
`default_nettype wire

// File: test/serial_flash_reset_recovery_test.sv
// self-checking bench joining host and device ends over the link
`timescale 1ns/100ps
`default_nettype none
module serial_flash_reset_recovery_test
    import sfrr_pkg::*;
;
    // shortened timing, in clock cycles
    localparam int T_LOW  = 20;
    localparam int T_BUSY = 100;
    localparam int T_DEC  = 80;
    localparam int T_RD   = 70;
    localparam int T_PRG  = 120;
    localparam int T_SEC  = 160;
    localparam int T_BLK  = 200;
    localparam int T_CHIP = 300;
    localparam int T_STS  = 240;
    localparam int T_STBY = 70;
    localparam int T_WAIT = 500;

    logic        clk;
    logic        rst_b;
    logic        hw_reset_req;
    logic        byte_req;
    logic [7:0]  byte_in;
    logic        byte_last;
    logic        busy;
    logic        can_send;
    logic        write_enable_latch;
    logic        write_in_progress;
    logic        addr_4byte;
    logic [15:0] lock_bits;
    logic        op_aborted;
    logic        data_corrupt;
    logic        sw_reset_done;
    int          errors;
    int          samples_checked;
    int          sw_cnt;
    logic [7:0]  op_tab [7] = '{OP_READ, OP_PROGRAM, OP_SECTOR_ERASE,
        OP_BLOCK_ERASE_M, OP_BLOCK_ERASE_L, OP_CHIP_ERASE, OP_STATUS_WRITE};
    int          len_tab [7] = '{4, 5, 4, 4, 4, 1, 2};
    int          rec_tab [7] = '{T_RD, T_PRG, T_SEC, T_BLK, T_BLK, T_CHIP,
        T_STS};

    sfrr_if i_sfrr_if ();

    sfrr_device #(.RESET_LOW_CYCLES(T_LOW), .OP_BUSY_CYCLES(T_BUSY),
        .RECOV_DECODE(T_DEC), .RECOV_READ(T_RD), .RECOV_PROGRAM(T_PRG),
        .RECOV_SECTOR(T_SEC), .RECOV_BLOCK(T_BLK), .RECOV_CHIP(T_CHIP),
        .RECOV_STATUS(T_STS), .RECOV_STANDBY(T_STBY)) i_sfrr_device (
        .clk(clk), .rst_b(rst_b), .bus(i_sfrr_if),
        .write_enable_latch(write_enable_latch),
        .write_in_progress(write_in_progress), .addr_4byte(addr_4byte),
        .lock_bits(lock_bits), .op_aborted(op_aborted),
        .data_corrupt(data_corrupt), .sw_reset_done(sw_reset_done));

    sfrr_host #(.RESET_LOW_CYCLES(T_LOW), .SELECT_WAIT(T_LOW),
        .RECOV_WAIT(T_WAIT))
    i_sfrr_host (
        .clk(clk), .rst_b(rst_b), .bus(i_sfrr_if),
        .hw_reset_req(hw_reset_req), .byte_req(byte_req),
        .byte_in(byte_in), .byte_last(byte_last), .busy(busy),
        .can_send(can_send));

    sfrr_properties #(.RST_LOW(T_LOW), .SEL_WAIT(T_LOW),
        .MIN_RECOV(T_STBY - 4), .MAX_RECOV(T_CHIP + 20)) i_sfrr_properties (
        .clk(clk), .rst_b(rst_b), .reset_n(i_sfrr_if.reset_n),
        .cs_n(i_sfrr_if.cs_n), .cmd_valid(i_sfrr_if.cmd_valid),
        .cmd_byte(i_sfrr_if.cmd_byte), .cmd_last(i_sfrr_if.cmd_last),
        .so_out(i_sfrr_if.so_out), .so_oe(i_sfrr_if.so_oe),
        .ready(i_sfrr_if.ready));

    // ==========================================================
    // clock, pulse counter, shared tasks
    // ==========================================================
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // counts software reset completions
    always @(posedge clk)
        if (sw_reset_done === 1'b1)
            sw_cnt++;

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        if (errors == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run

    // one byte through the host, single select when last is set
    task automatic send_byte(input logic [7:0] b, input logic last);
        repeat (600) if (can_send !== 1'b1) @(posedge clk);
        byte_req  <= 1'b1;
        byte_in   <= b;
        byte_last <= last;
        @(posedge clk);
        byte_req  <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : send_byte

    task automatic wait_ready();
        repeat (1000) if (i_sfrr_if.ready !== 1'b1) @(posedge clk);
    endtask : wait_ready

    // hardware reset; gives cycles from release to ready
    task automatic hw_reset(output int rec, output logic ab);
        hw_reset_req <= 1'b1;
        @(posedge clk);
        hw_reset_req <= 1'b0;
        repeat (10) if (i_sfrr_if.reset_n !== 1'b0) @(posedge clk);
        @(posedge clk);
        ab = op_aborted;                // abort flag stands one cycle
        repeat (100) if (i_sfrr_if.reset_n !== 1'b1) @(posedge clk);
        rec = 0;
        while (i_sfrr_if.ready !== 1'b1 && rec < 1000)
        begin
            rec++;
            @(posedge clk);
        end
        repeat (1000) if (busy !== 1'b0) @(posedge clk);
    endtask : hw_reset

    // ==========================================================
    // scenarios
    // ==========================================================
    task automatic test_volatile();
        int   rec;
        logic ab;
        wait_ready();
        check("ready", i_sfrr_if.ready, 1);
        check("wel", write_enable_latch, 0);
        check("locks", lock_bits, LOCK_DEFAULT);
        send_byte(OP_WRITE_ENABLE, 1'b1);
        check("wel set", write_enable_latch, 1);
        send_byte(OP_BLOCK_LOCK, 1'b1);
        check("locks clear", lock_bits, 16'h0000);
        hw_reset(rec, ab);
        check("wel", write_enable_latch, 0);
        check("locks", lock_bits, LOCK_DEFAULT);
        check("addr4", addr_4byte, ADDR4_DEFAULT);
    endtask : test_volatile

    // reset during each kind of operation, recovery per kind
    task automatic test_abort();
        int   rec;
        logic ab;
        logic ok;
        for (int i = 0; i < 7; i++)
        begin
            send_byte(OP_WRITE_ENABLE, 1'b1);
            for (int k = 0; k < len_tab[i]; k++)
                send_byte(k == 0 ? op_tab[i] : 8'h00, k == len_tab[i] - 1);
            check("wip", write_in_progress, i != 0);
            hw_reset(rec, ab);
            check("aborted", ab, i != 0);
            check("corrupt", data_corrupt, i != 0);
            check("wip clear", write_in_progress, 0);
            check("wel clear", write_enable_latch, 0);
            ok = rec >= rec_tab[i] - 3 && rec <= rec_tab[i] + 3;
            check("rec", ok, 1);
            check("rec", ok, 1);
        end
        // reset in the middle of a command, before its last byte
        send_byte(OP_READ, 1'b0);
        hw_reset(rec, ab);
        ok = rec >= T_DEC - 3 && rec <= T_DEC + 3;
        check("rec decode", ok, 1);
    endtask : test_abort

    // software reset pairing and host hold-off during recovery
    task automatic test_sw_reset();
        int n;
        n = sw_cnt;
        send_byte(OP_RESET, 1'b1);
        send_byte(OP_RESET_ENABLE, 1'b1);
        send_byte(OP_WRITE_ENABLE, 1'b1);
        send_byte(OP_RESET, 1'b1);
        check("sw ignored", 16'(sw_cnt - n), 0);
        check("ready kept", i_sfrr_if.ready, 1);
        check("wel set", write_enable_latch, 1);
        send_byte(OP_RESET_ENABLE, 1'b1);
        send_byte(OP_RESET, 1'b1);
        check("sw done", 16'(sw_cnt - n), 1);
        check("not ready", i_sfrr_if.ready, 0);
        check("wel clear", write_enable_latch, 0);
        check("hold off", can_send, 0);
        send_byte(OP_WRITE_ENABLE, 1'b1);
        check("wel after", write_enable_latch, 1);
    endtask : test_sw_reset

    // watchdog
    initial
    begin
        repeat (30000) @(posedge clk);
        errors++;
        complete_run();
    end

    // main sequence
    initial
    begin
        rst_b        = 1'b0;
        hw_reset_req = 1'b0;
        byte_req     = 1'b0;
        byte_in      = 8'h00;
        byte_last    = 1'b0;
        errors       = 0;
        samples_checked = 0;
        sw_cnt       = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        test_volatile();
        test_abort();
        test_sw_reset();
        complete_run();
    end
endmodule : serial_flash_reset_recovery_test
`default_nettype wire
